// ### bench/port_pin_direction_and_function_mux_tb.sv
// self-checking bench for the port control block
`timescale 1ns/1ps
`default_nettype none
`include "ppm_params.svh"
module port_pin_direction_and_function_mux_tb;
    logic       i_clk, i_rst_n, i_wr, i_rd, i_timer0_comp_mode;
    logic [1:0] i_port, i_rsel;
    logic [7:0] i_wdata, o_rdata, i_pa_in, i_pb_in, i_pc_in, lvl_a, lvl_b, per;
    logic [7:0] o_pa_out, o_pa_oe, o_pb_out, o_pb_oe, o_pc_out, o_pc_oe, o_analog_en;
    logic       i_timer0_output, i_timer0_comp_output, i_timer1_output, i_timer1_comp_output;
    logic       i_line_driver_enable_out, i_serial_transmit_out, i_comparator_output;
    logic       o_timer0_input, o_timer1_input, o_external_clock_input, o_ext_reset_n;
    logic       o_clear_to_send_in, o_serial_receive_in;
    int         err_total, checked;
    assign {i_comparator_output, i_serial_transmit_out, i_line_driver_enable_out, i_timer1_comp_output,
            i_timer1_output, i_timer0_comp_output, i_timer0_output} = per[6:0];
    ppm_port_mux #(.WIDTH(8)) DUT (.*);
    ppm_board u_brd_a (.i_oe(o_pa_oe), .i_out(o_pa_out), .i_level(lvl_a), .o_pin(i_pa_in));
    ppm_board u_brd_b (.i_oe(o_pb_oe), .i_out(o_pb_out), .i_level(lvl_b), .o_pin(i_pb_in));
    ppm_board u_brd_c (.i_oe(o_pc_oe), .i_out(o_pc_out), .i_level(~lvl_b), .o_pin(i_pc_in));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic wr(input logic [1:0] p, input logic [1:0] r, input logic [7:0] d);
        @(posedge i_clk);
        i_port  <= p;
        i_rsel  <= r;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic sub(input logic [1:0] p, input logic [7:0] idx, input logic [7:0] d);
        wr(p, `PPM_RSEL_ADDR, idx);
        wr(p, `PPM_RSEL_CTRL, d);
    endtask
    // read data is held until the next read, so a late look is safe
    task automatic rdchk(input logic [1:0] p, input logic [1:0] r, input logic [7:0] exp);
        @(posedge i_clk);
        i_port <= p;
        i_rsel <= r;
        i_rd   <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        step(1);
        chk(o_rdata, exp);
    endtask
    task automatic report_and_stop;
        if (err_total == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end
    initial begin
        #(50 * 4000);
        err_total++;
        report_and_stop();
    end
    initial begin
        {i_rst_n, i_wr, i_rd, i_timer0_comp_mode, i_port, i_rsel, i_wdata, per} = '0;
        lvl_a = 8'h5A;
        lvl_b = 8'h3C;
        err_total = 0;
        checked = 0;
        repeat (8) @(posedge i_clk);
        i_rst_n <= 1'b1;
        wr(`PPM_PORT_A, `PPM_RSEL_ADDR, `PPM_SUB_DIR);
        rdchk(`PPM_PORT_A, `PPM_RSEL_CTRL, `PPM_DIR_RST);
        wr(`PPM_PORT_A, `PPM_RSEL_ADDR, `PPM_SUB_AFEN);
        rdchk(`PPM_PORT_A, `PPM_RSEL_CTRL, 8'h00);
        rdchk(`PPM_PORT_A, `PPM_RSEL_ADDR, 8'h02);
        rdchk(2'h3, `PPM_RSEL_CTRL, 8'h00);
        sub(`PPM_PORT_A, `PPM_SUB_DIR, 8'h0F);
        wr(`PPM_PORT_A, `PPM_RSEL_OUT, 8'hC3);
        rdchk(`PPM_PORT_A, `PPM_RSEL_OUT, 8'hC3);
        chk(o_pa_oe, 8'hF0);
        chk(o_pa_out & o_pa_oe, 8'hC0);
        // bits turned to outputs keep the level they last sampled as inputs
        rdchk(`PPM_PORT_A, `PPM_RSEL_IN, 8'h5A);
        // port B has its own copy: A's direction write must not reach it
        wr(`PPM_PORT_B, `PPM_RSEL_ADDR, `PPM_SUB_DIR);
        rdchk(`PPM_PORT_B, `PPM_RSEL_CTRL, 8'hFF);
        wr(`PPM_PORT_B, `PPM_RSEL_CTRL, 8'hF0);
        wr(`PPM_PORT_B, `PPM_RSEL_OUT, 8'hAA);
        step(2);
        chk(o_pb_oe, 8'h0F);
        chk(o_pb_out & o_pb_oe, 8'h0A);
        rdchk(`PPM_PORT_C, `PPM_RSEL_IN, 8'hC3);
        sub(`PPM_PORT_C, `PPM_SUB_DIR, 8'h00);
        wr(`PPM_PORT_C, `PPM_RSEL_OUT, 8'h96);
        step(2);
        chk(o_pc_out & o_pc_oe, 8'h96);
        rdchk(`PPM_PORT_A, `PPM_RSEL_CTRL, 8'h0F);
        // selects first, enable last; only pins that have a function
        sub(`PPM_PORT_A, `PPM_SUB_FSL, 8'h08);
        sub(`PPM_PORT_A, `PPM_SUB_FSH, 8'h2C);
        sub(`PPM_PORT_A, `PPM_SUB_AFEN, 8'h2E);
        for (int k = 0; k < 2; k++) begin
            @(posedge i_clk);
            per   <= k ? 8'h01 : 8'h08;
            lvl_a <= k ? 8'hA5 : 8'h5A;
            step(5);
            chk(o_pa_oe, 8'hF2);
            chk(o_pa_out & o_pa_oe, k ? 8'hC2 : 8'hE0);
            chk(o_analog_en, 8'h08);
            chk({7'h0, o_ext_reset_n}, k ? 8'h01 : 8'h00);
        end
        sub(`PPM_PORT_A, `PPM_SUB_AFEN, 8'h00);
        sub(`PPM_PORT_A, `PPM_SUB_FSL, 8'h0F);
        sub(`PPM_PORT_A, `PPM_SUB_FSH, 8'h01);
        sub(`PPM_PORT_A, `PPM_SUB_AFEN, 8'h1F);
        for (int k = 0; k < 2; k++) begin
            @(posedge i_clk);
            i_timer0_comp_mode <= k[0];
            per   <= k ? 8'h06 : 8'h00;
            lvl_a <= k ? 8'h5A : 8'hA5;
            step(5);
            chk(o_pa_oe, k ? 8'hE5 : 8'hE4);
            chk(o_pa_out & o_pa_oe, k ? 8'hC5 : 8'hC0);
            chk({4'h0, o_serial_receive_in, o_timer1_input, o_external_clock_input, o_timer0_input},
                k ? 8'h0E : 8'h01);
            chk(o_analog_en, 8'h00);
        end
        // pin 3 swaps clear to send for comparator out; the pin is high both times
        for (int k = 0; k < 2; k++) begin
            sub(`PPM_PORT_A, `PPM_SUB_AFEN, 8'h00);
            sub(`PPM_PORT_A, `PPM_SUB_FSL, 8'h12);
            sub(`PPM_PORT_A, `PPM_SUB_FSH, k ? 8'h1A : 8'h12);
            sub(`PPM_PORT_A, `PPM_SUB_AFEN, 8'h3E);
            @(posedge i_clk);
            per   <= k ? 8'h60 : 8'h10;
            lvl_a <= 8'hFF;
            step(5);
            chk(o_pa_oe, k ? 8'hEC : 8'hE4);
            chk(o_pa_out & o_pa_oe, k ? 8'hE8 : 8'hC4);
            chk({7'h0, o_clear_to_send_in}, k ? 8'h00 : 8'h01);
            chk(o_analog_en, 8'h12);
        end
        @(posedge i_clk);
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1'b1;
        step(1);
        chk(o_pa_oe, 8'h00);
        rdchk(`PPM_PORT_A, `PPM_RSEL_ADDR, `PPM_ADDR_RST);
        report_and_stop();
    end
endmodule
`default_nettype wire

// ### bench/ppm_board.sv
// board model behind one port's pins
`timescale 1ns/1ps
`default_nettype none
module ppm_board (
    input  wire logic [7:0] i_oe,
    input  wire logic [7:0] i_out,
    input  wire logic [7:0] i_level,
    output logic      [7:0] o_pin
);
    // released pins take the board level, never the last driven value
    assign o_pin = (i_oe & i_out) | (~i_oe & i_level);
endmodule
`default_nettype wire

// ### bench/ppm_port_mux_monitor.sv
// port control checker, bound onto the top module
`timescale 1ns/1ps
`default_nettype none
`include "ppm_params.svh"
module ppm_port_mux_monitor
    import ppm_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input wire logic             i_clk,
    input wire logic             i_rst_n,
    input wire ppm_port_t        i_port,
    input wire ppm_rsel_t        i_rsel,
    input wire logic             i_wr,
    input wire logic             i_rd,
    input wire logic [7:0]       i_wdata,
    input wire logic [7:0]       o_rdata,
    input wire logic [WIDTH-1:0] i_pa_in,
    input wire logic [WIDTH-1:0] o_pa_oe,
    input wire logic [WIDTH-1:0] o_pb_out,
    input wire logic [WIDTH-1:0] o_pb_oe,
    input wire logic [WIDTH-1:0] o_pc_oe,
    input wire logic [WIDTH-1:0] o_analog_en,
    input wire logic             o_ext_reset_n,
    input wire logic             o_serial_receive_in,
    input wire logic             o_timer0_input,
    input wire logic             o_timer1_input,
    input wire logic             o_external_clock_input
);
    // port B shadow: it has no alternate functions, so its pins are pure GPIO
    logic [7:0] pb_addr_reg, pb_addr_next, pb_dir_reg, pb_dir_next, pb_out_reg, pb_out_next;
    always_comb begin
        pb_addr_next = pb_addr_reg;
        pb_dir_next  = pb_dir_reg;
        pb_out_next  = pb_out_reg;
        if (i_wr && i_port == `PPM_PORT_B) begin
            if (i_rsel == `PPM_RSEL_ADDR) pb_addr_next = i_wdata;
            if (i_rsel == `PPM_RSEL_CTRL && pb_addr_reg == `PPM_SUB_DIR) pb_dir_next = i_wdata;
            if (i_rsel == `PPM_RSEL_OUT) pb_out_next = i_wdata;
        end
    end
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            pb_addr_reg <= `PPM_ADDR_RST;
            pb_dir_reg  <= `PPM_DIR_RST;
            pb_out_reg  <= `PPM_OUT_RST;
        end else begin
            pb_addr_reg <= pb_addr_next;
            pb_dir_reg  <= pb_dir_next;
            pb_out_reg  <= pb_out_next;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking dcb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // two quiet samples tolerate either output latency of the shadow
    sequence pb_quiet;
        $stable(pb_dir_reg) && $stable(pb_out_reg) ##1 $stable(pb_dir_reg) && $stable(pb_out_reg);
    endsequence
    AST_RST_DRV: assert property ($past(i_rst_n) == 1'b0 |-> (o_pa_oe | o_pb_oe | o_pc_oe | o_analog_en) == 0)
        else $error("pins driven right after reset");
    AST_RST_IDLE: assert property ($past(i_rst_n) == 1'b0 |-> o_ext_reset_n && o_serial_receive_in && !o_timer0_input && !o_timer1_input)
        else $error("peripheral inputs not idle after reset");
    AST_RD_HOLD: assert property ($past(i_rd) == 1'b0 |-> $stable(o_rdata))
        else $error("read data changed without a read");
    AST_NOPORT: assert property (i_rd && i_port == 2'h3 |=> o_rdata == 8'h00)
        else $error("read of missing port not zero");
    AST_PB_OE: assert property (pb_quiet |-> o_pb_oe == ~pb_dir_reg)
        else $error("port B enable differs from direction");
    AST_PB_OUT: assert property (pb_quiet |-> (o_pb_out & o_pb_oe) == (pb_out_reg & ~pb_dir_reg))
        else $error("port B drive value differs from output data");
    AST_AN_OFF: assert property ((o_analog_en & o_pa_oe) == 8'h00)
        else $error("analog pin has its driver on");
    AST_XRST: assert property (!o_ext_reset_n |-> $past(i_pa_in[2], 3) == 1'b0)
        else $error("external reset low without the pin low");
    AST_TIMER1_INPUT: assert property (o_timer1_input |-> $past(i_pa_in[3], 3))
        else $error("timer 1 input high without the pin high");
    AST_EXTERNAL_CLOCK_INPUT: assert property (o_external_clock_input |-> $past(i_pa_in[1], 3))
        else $error("clock input high without the pin high");
    COV_XRST: cover property (!o_ext_reset_n);
    COV_ANALOG: cover property (o_analog_en != 0);
    COV_NOPORT: cover property (i_rd && i_port == 2'h3);
endmodule
bind ppm_port_mux ppm_port_mux_monitor #(.WIDTH(WIDTH)) u_monitor (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_port(i_port), .i_rsel(i_rsel), .i_wr(i_wr), .i_rd(i_rd),
    .i_wdata(i_wdata), .o_rdata(o_rdata), .i_pa_in(i_pa_in), .o_pa_oe(o_pa_oe), .o_pb_out(o_pb_out),
    .o_pb_oe(o_pb_oe), .o_pc_oe(o_pc_oe), .o_analog_en(o_analog_en), .o_ext_reset_n(o_ext_reset_n),
    .o_serial_receive_in(o_serial_receive_in), .o_timer0_input(o_timer0_input),
    .o_timer1_input(o_timer1_input), .o_external_clock_input(o_external_clock_input)
);
`default_nettype wire

// ### design/ppm_params.svh
// register indices, subregister codes and reset values for the port control block
`ifndef PPM_PARAMS_SVH
`define PPM_PARAMS_SVH

`define PPM_RSEL_ADDR    2'h0
`define PPM_RSEL_CTRL    2'h1
`define PPM_RSEL_IN      2'h2
`define PPM_RSEL_OUT     2'h3

`define PPM_SUB_DIR      8'h01
`define PPM_SUB_AFEN     8'h02
`define PPM_SUB_FSL      8'h07
`define PPM_SUB_FSH      8'h08

`define PPM_ADDR_RST     8'h00
`define PPM_DIR_RST      8'hFF
`define PPM_AFEN_RST     8'h00
`define PPM_FSL_RST      8'h00
`define PPM_FSH_RST      8'h00
`define PPM_OUT_RST      8'h00
`define PPM_IN_RST       8'h00

`define PPM_NUM_PORTS    3
`define PPM_PORT_A       2'h0
`define PPM_PORT_B       2'h1
`define PPM_PORT_C       2'h2

`endif

// ### design/ppm_pkg.sv
// types shared by the port control block
package ppm_pkg;
    typedef logic [1:0] ppm_rsel_t;
    typedef logic [1:0] ppm_port_t;
    typedef logic [7:0] ppm_byte_t;
    // code is {function_select_low, function_select_high}
    typedef enum logic [1:0] {
        PPM_FN_00 = 2'h0,
        PPM_FN_01 = 2'h1,
        PPM_FN_10 = 2'h2,
        PPM_FN_11 = 2'h3
    } ppm_fn_e;
endpackage

// ### design/ppm_port_mux.sv
// ports A to C: register access, pin direction and port A alternate function routing
// What this block does
// - Writing 01H to a port's address register makes its control register reach the pin direction subregister.
// - Writing 02H to a port's address register makes its control register reach the alternate function enable subregister.
// - A pin whose direction bit is 0 drives the matching output data bit.
// - A pin whose direction bit is 1 has its driver off and its sampled level stored in the input data register.
// - An enabled alternate function controls the pin whatever its direction bit says.
// - With the enable bit clear a pin is plain GPIO, with it set on pins A0 to A5 the two select bits pick the function.
// - Pin A0 gives timer 0 input or timer 0 complement on both 00 and 11, the timer mode picking; pin A1 gives timer 0 output, clock in, analog.
// - Pin A2 gives driver enable on 00, external reset on 01 and timer 1 output on 10.
// - Pin A3 gives clear to send on 00, comparator out on 01, timer 1 input on 10 and analog on 11.
// - Pin A4 gives receive data on 00 and analog on 11; pin A5 gives transmit, timer 1 complement, analog.
// - Analog selection acts only while the pin's enable bit is set.
// - A pin with timer input and complement output uses one setting and the timer mode picks the function.
`timescale 1ns/1ps
`default_nettype none
`include "ppm_params.svh"

module ppm_port_mux
    import ppm_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst_n,
    input  wire ppm_port_t        i_port,
    input  wire ppm_rsel_t        i_rsel,
    input  wire logic             i_wr,
    input  wire logic             i_rd,
    input  wire logic [7:0]       i_wdata,
    output logic      [7:0]       o_rdata,
    input  wire logic [WIDTH-1:0] i_pa_in,
    input  wire logic [WIDTH-1:0] i_pb_in,
    input  wire logic [WIDTH-1:0] i_pc_in,
    output logic      [WIDTH-1:0] o_pa_out,
    output logic      [WIDTH-1:0] o_pa_oe,
    output logic      [WIDTH-1:0] o_pb_out,
    output logic      [WIDTH-1:0] o_pb_oe,
    output logic      [WIDTH-1:0] o_pc_out,
    output logic      [WIDTH-1:0] o_pc_oe,
    input  wire logic             i_timer0_output,
    input  wire logic             i_timer0_comp_output,
    input  wire logic             i_timer0_comp_mode,
    input  wire logic             i_timer1_output,
    input  wire logic             i_timer1_comp_output,
    input  wire logic             i_line_driver_enable_out,
    input  wire logic             i_serial_transmit_out,
    input  wire logic             i_comparator_output,
    output logic                  o_timer0_input,
    output logic                  o_timer1_input,
    output logic                  o_external_clock_input,
    output logic                  o_ext_reset_n,
    output logic                  o_clear_to_send_in,
    output logic                  o_serial_receive_in,
    output logic      [WIDTH-1:0] o_analog_en
);

    localparam int NP = `PPM_NUM_PORTS;

    logic [WIDTH-1:0] pin_meta [NP];
    logic [WIDTH-1:0] pin_sync [NP];
    logic [WIDTH-1:0] pin_raw  [NP];
    logic [7:0]       addr     [NP];
    logic [WIDTH-1:0] dir      [NP];
    logic [WIDTH-1:0] afen     [NP];
    logic [WIDTH-1:0] fsl      [NP];
    logic [WIDTH-1:0] fsh      [NP];
    logic [WIDTH-1:0] odata    [NP];
    logic [WIDTH-1:0] idata    [NP];
    logic [WIDTH-1:0] out_next [NP];
    logic [WIDTH-1:0] oe_next  [NP];
    logic [WIDTH-1:0] ana_next;
    logic             t0_in_next;
    logic             t1_in_next;
    logic             clk_in_next;
    logic             rst_n_next;
    logic             cts_next;
    logic             rxd_next;
    logic [7:0]       rdata_next;

    assign pin_raw[0] = i_pa_in;
    assign pin_raw[1] = i_pb_in;
    assign pin_raw[2] = i_pc_in;

    ////////////////////////////////////////////////////////////////////////////
    // pins are asynchronous to i_clk: two stages before anything reads them
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            for (int p = 0; p < NP; p++) begin
                pin_meta[p] <= '0;
                pin_sync[p] <= '0;
            end
        end else begin
            for (int p = 0; p < NP; p++) begin
                pin_meta[p] <= pin_raw[p];
                pin_sync[p] <= pin_meta[p];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    for (genvar p = 0; p < NP; p++) begin : g_port
        ppm_port_regs #(
            .WIDTH (WIDTH)
        ) u_regs (
            .i_clk      (i_clk),
            .i_rst_n    (i_rst_n),
            .i_wr       (i_wr && i_port == ppm_port_t'(p)),
            .i_rsel     (i_rsel),
            .i_wdata    (i_wdata),
            .i_pin_sync (pin_sync[p]),
            .o_addr     (addr[p]),
            .o_dir      (dir[p]),
            .o_afen     (afen[p]),
            .o_fsl      (fsl[p]),
            .o_fsh      (fsh[p]),
            .o_out_data (odata[p]),
            .o_in_data  (idata[p])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data held until the next read
    always_comb begin
        rdata_next = o_rdata;
        if (i_rd) begin
            rdata_next = 8'h00;
            for (int p = 0; p < NP; p++) begin
                if (i_port == ppm_port_t'(p)) begin
                    case (i_rsel)
                        `PPM_RSEL_ADDR: rdata_next = addr[p];
                        `PPM_RSEL_IN:   rdata_next = 8'(idata[p]);
                        `PPM_RSEL_OUT:  rdata_next = 8'(odata[p]);
                        default: begin
                            case (addr[p])
                                `PPM_SUB_DIR:  rdata_next = 8'(dir[p]);
                                `PPM_SUB_AFEN: rdata_next = 8'(afen[p]);
                                `PPM_SUB_FSL:  rdata_next = 8'(fsl[p]);
                                `PPM_SUB_FSH:  rdata_next = 8'(fsh[p]);
                                default:       rdata_next = 8'h00;
                            endcase
                        end
                    endcase
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin drive: GPIO everywhere, then port A alternate functions override
    always_comb begin
        ppm_fn_e fn;
        fn = PPM_FN_00;
        for (int p = 0; p < NP; p++) begin
            out_next[p] = odata[p];
            oe_next[p]  = ~dir[p];
        end
        ana_next    = '0;
        t0_in_next  = 1'b0;
        t1_in_next  = 1'b0;
        clk_in_next = 1'b0;
        rst_n_next  = 1'b1;
        cts_next    = 1'b0;
        rxd_next    = 1'b1;
        // pins 6 and up have no mapped function here and stay GPIO
        for (int b = 0; b < 6 && b < WIDTH; b++) begin
            if (afen[0][b]) begin
                fn = ppm_fn_e'({fsl[0][b], fsh[0][b]});
                // default for an enabled pin: driver off (inputs, analog, reserved codes)
                oe_next[0][b]  = 1'b0;
                out_next[0][b] = 1'b0;
                case (b)
                    0: begin
                        // one setting serves both, timer mode decides
                        if (fn == PPM_FN_00 || fn == PPM_FN_11) begin
                            if (i_timer0_comp_mode) begin
                                oe_next[0][b]  = 1'b1;
                                out_next[0][b] = i_timer0_comp_output;
                            end else begin
                                t0_in_next = pin_sync[0][b];
                            end
                        end
                    end
                    1: begin
                        case (fn)
                            PPM_FN_00: begin
                                oe_next[0][b]  = 1'b1;
                                out_next[0][b] = i_timer0_output;
                            end
                            PPM_FN_10: clk_in_next = pin_sync[0][b];
                            PPM_FN_11: ana_next[b] = 1'b1;
                            default: ;
                        endcase
                    end
                    2: begin
                        case (fn)
                            PPM_FN_00: begin
                                oe_next[0][b]  = 1'b1;
                                out_next[0][b] = i_line_driver_enable_out;
                            end
                            PPM_FN_01: rst_n_next = pin_sync[0][b];
                            PPM_FN_10: begin
                                oe_next[0][b]  = 1'b1;
                                out_next[0][b] = i_timer1_output;
                            end
                            default: ;
                        endcase
                    end
                    3: begin
                        case (fn)
                            PPM_FN_00: cts_next = pin_sync[0][b];
                            PPM_FN_01: begin
                                oe_next[0][b]  = 1'b1;
                                out_next[0][b] = i_comparator_output;
                            end
                            PPM_FN_10: t1_in_next = pin_sync[0][b];
                            PPM_FN_11: ana_next[b] = 1'b1;
                            default: ;
                        endcase
                    end
                    4: begin
                        case (fn)
                            PPM_FN_00: rxd_next = pin_sync[0][b];
                            PPM_FN_11: ana_next[b] = 1'b1;
                            default: ;
                        endcase
                    end
                    default: begin
                        case (fn)
                            PPM_FN_00: begin
                                oe_next[0][b]  = 1'b1;
                                out_next[0][b] = i_serial_transmit_out;
                            end
                            PPM_FN_01: begin
                                oe_next[0][b]  = 1'b1;
                                out_next[0][b] = i_timer1_comp_output;
                            end
                            PPM_FN_11: ana_next[b] = 1'b1;
                            default: ;
                        endcase
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_rdata                <= 8'h00;
            o_pa_out               <= '0;
            o_pa_oe                <= '0;
            o_pb_out               <= '0;
            o_pb_oe                <= '0;
            o_pc_out               <= '0;
            o_pc_oe                <= '0;
            o_analog_en            <= '0;
            o_timer0_input         <= 1'b0;
            o_timer1_input         <= 1'b0;
            o_external_clock_input <= 1'b0;
            o_ext_reset_n          <= 1'b1;
            o_clear_to_send_in     <= 1'b0;
            o_serial_receive_in    <= 1'b1;
        end else begin
            o_rdata                <= rdata_next;
            o_pa_out               <= out_next[0];
            o_pa_oe                <= oe_next[0];
            o_pb_out               <= out_next[1];
            o_pb_oe                <= oe_next[1];
            o_pc_out               <= out_next[2];
            o_pc_oe                <= oe_next[2];
            o_analog_en            <= ana_next;
            o_timer0_input         <= t0_in_next;
            o_timer1_input         <= t1_in_next;
            o_external_clock_input <= clk_in_next;
            o_ext_reset_n          <= rst_n_next;
            o_clear_to_send_in     <= cts_next;
            o_serial_receive_in    <= rxd_next;
        end
    end

endmodule
`default_nettype wire

// ### design/ppm_port_regs.sv
// one port's address, direction, alternate function, output and input data registers
`timescale 1ns/1ps
`default_nettype none
`include "ppm_params.svh"

module ppm_port_regs
    import ppm_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst_n,
    input  wire logic             i_wr,
    input  wire ppm_rsel_t        i_rsel,
    input  wire logic [7:0]       i_wdata,
    input  wire logic [WIDTH-1:0] i_pin_sync,
    output logic      [7:0]       o_addr,
    output logic      [WIDTH-1:0] o_dir,
    output logic      [WIDTH-1:0] o_afen,
    output logic      [WIDTH-1:0] o_fsl,
    output logic      [WIDTH-1:0] o_fsh,
    output logic      [WIDTH-1:0] o_out_data,
    output logic      [WIDTH-1:0] o_in_data
);

    logic [7:0]       addr_next;
    logic [WIDTH-1:0] dir_next;
    logic [WIDTH-1:0] afen_next;
    logic [WIDTH-1:0] fsl_next;
    logic [WIDTH-1:0] fsh_next;
    logic [WIDTH-1:0] out_next;
    logic [WIDTH-1:0] in_next;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        addr_next = o_addr;
        dir_next  = o_dir;
        afen_next = o_afen;
        fsl_next  = o_fsl;
        fsh_next  = o_fsh;
        out_next  = o_out_data;
        if (i_wr && i_rsel == `PPM_RSEL_ADDR) begin
            addr_next = i_wdata;
        end
        if (i_wr && i_rsel == `PPM_RSEL_OUT) begin
            out_next = i_wdata[WIDTH-1:0];
        end
        if (i_wr && i_rsel == `PPM_RSEL_CTRL) begin
            case (o_addr)
                `PPM_SUB_DIR:  dir_next  = i_wdata[WIDTH-1:0];
                `PPM_SUB_AFEN: afen_next = i_wdata[WIDTH-1:0];
                `PPM_SUB_FSL:  fsl_next  = i_wdata[WIDTH-1:0];
                `PPM_SUB_FSH:  fsh_next  = i_wdata[WIDTH-1:0];
                default: ;
            endcase
        end
        // only pins set as inputs refresh their bit
        in_next = (i_pin_sync & o_dir) | (o_in_data & ~o_dir);
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_addr     <= `PPM_ADDR_RST;
            o_dir      <= WIDTH'(`PPM_DIR_RST);
            o_afen     <= WIDTH'(`PPM_AFEN_RST);
            o_fsl      <= WIDTH'(`PPM_FSL_RST);
            o_fsh      <= WIDTH'(`PPM_FSH_RST);
            o_out_data <= WIDTH'(`PPM_OUT_RST);
            o_in_data  <= WIDTH'(`PPM_IN_RST);
        end else begin
            o_addr     <= addr_next;
            o_dir      <= dir_next;
            o_afen     <= afen_next;
            o_fsl      <= fsl_next;
            o_fsh      <= fsh_next;
            o_out_data <= out_next;
            o_in_data  <= in_next;
        end
    end

endmodule
`default_nettype wire
